//--- include/hpr_cfg.svh
// constants for the host register port: offsets, bit positions, resets
`ifndef HPR_CFG_SVH
`define HPR_CFG_SVH

// word select codes on {reg_sel_top, reg_sel_a, reg_sel_b}
`define HPR_SEL_DATA      3'h0
`define HPR_SEL_DATA_INC  3'h1
`define HPR_SEL_ADDR      3'h2
`define HPR_SEL_CMDSTS    3'h3
`define HPR_SEL_CTRL      3'h4
`define HPR_SEL_ADDR2     3'h5
`define HPR_SEL_ADDR_EXT  3'h6
`define HPR_SEL_LEN       3'h7

// adapter control bit positions
`define HPR_CTL_CFG_LO    0
`define HPR_CTL_CFG_HI    2
`define HPR_CTL_RSVD      3
`define HPR_CTL_ACK       4
`define HPR_CTL_DIR       5
`define HPR_CTL_REQ       6
`define HPR_CTL_ENABLE    7
`define HPR_CTL_ADAPTER_RESET_BIT    8
`define HPR_CTL_HALT      9

// reset values of the writable control bits
`define HPR_RST_ACK       1'b0
`define HPR_RST_ENABLE    1'b0
`define HPR_RST_ADAPTER_RESET_BIT    1'b1
`define HPR_RST_HALT      1'b1

// reset values of the word registers
`define HPR_RST_WORD      16'h0000
`define HPR_RST_BYTE      8'h00

// pointer step after an auto-increment access, in bytes
`define HPR_ADDR_STEP     16'h0002

// size of the local window memory, in words, and its index width
`define HPR_MEM_WORDS     64
`define HPR_MEM_AW        6

// synchronised input vector width
`define HPR_SYNC_W        34

`endif

//--- include/hpr_pkg.sv
// types shared by the host register port modules
package hpr_pkg;

	// target of one decoded host access
	typedef enum logic [3:0] {
		HPR_T_DATA,
		HPR_T_DATA_INC,
		HPR_T_ADDR,
		HPR_T_CMDSTS,
		HPR_T_CTRL,
		HPR_T_ADDR_EXT,
		HPR_T_LEN,
		HPR_T_PDATA,
		HPR_T_PADDR,
		HPR_T_PADDR_EXT
	} hpr_target_type;

	// decoded network configuration
	typedef enum logic [2:0] {
		HPR_NET_RESERVED,
		HPR_NET_RING16,
		HPR_NET_CSMA,
		HPR_NET_RING4
	} hpr_net_type;

	// host access sequencer
	typedef enum logic [1:0] {
		HPR_ST_IDLE,
		HPR_ST_BUSY
	} hpr_state_type;

endpackage : hpr_pkg

//--- src/hpr_sync.sv
// two flip-flop synchroniser, one stage pair per bit
`timescale 1ns/1ns
module hpr_sync
	import hpr_pkg::*;
#(
	parameter int W = 1
)(
	input  wire logic         i_ref_clk,
	input  wire logic         i_rst_n,
	input  wire logic [W-1:0] i_async,
	output logic      [W-1:0] o_sync
);

	genvar gi;
	generate
		for (gi = 0; gi < W; gi = gi + 1)
		begin : g_bit
			logic meta; // first stage, read only by the second
			always_ff @(posedge i_ref_clk or negedge i_rst_n)
			begin
				if (!i_rst_n)
				begin
					meta      <= 1'b0;
					o_sync[gi] <= 1'b0;
				end
				else
				begin
					meta      <= i_async[gi];
					o_sync[gi] <= meta;
				end
			end
		end
	endgenerate

endmodule : hpr_sync

//--- src/hpr_decode.sv
// select line and strobe decode into a register target and byte lanes
`timescale 1ns/1ns
`include "hpr_cfg.svh"
module hpr_decode
	import hpr_pkg::*;
(
	input  wire logic     i_byte_strobe_style, // 1 byte strobes, 0 data strobes
	input  wire logic     i_byte_width_select, // 1 eight-bit port
	input  wire logic     i_reg_sel_top,
	input  wire logic     i_reg_sel_a,
	input  wire logic     i_reg_sel_b,
	input  wire logic     i_reg_sel_c,
	input  wire logic     i_byte_high_enable_n,
	input  wire logic     i_upper_strobe_n,
	input  wire logic     i_lower_strobe_n,
	input  wire logic     i_pseudo_active,
	output hpr_target_type o_target,
	output logic          o_lane_hi,   // high byte addressed
	output logic          o_lane_lo,   // low byte addressed
	output logic          o_narrow,    // byte travels on low data lane
	output logic          o_undefined  // combination selects nothing
);

	wire [2:0] word_sel  = {i_reg_sel_top, i_reg_sel_a, i_reg_sel_b};
	wire       remap     = i_pseudo_active & ~i_reg_sel_top;
	// eight-bit port: lowest select bit picks the byte, high enable ignored
	wire       w8_hi     = i_reg_sel_c;
	// byte strobe 16-bit: reg_sel_c low with high enable is a word
	wire       b16_hi    = ~i_byte_high_enable_n;
	wire       b16_lo    = ~i_reg_sel_c;
	// data strobes: each strobe owns its lane, both make a word
	wire       ds_hi     = ~i_upper_strobe_n;
	wire       ds_lo     = ~i_lower_strobe_n;
	wire       b16_bad   = i_byte_high_enable_n & i_reg_sel_c;

	assign o_narrow    = i_byte_strobe_style & i_byte_width_select;
	assign o_undefined = i_byte_strobe_style & ~i_byte_width_select & b16_bad;
	assign o_lane_hi   = !i_byte_strobe_style ? ds_hi :
	                     i_byte_width_select ? w8_hi : b16_hi;
	assign o_lane_lo   = !i_byte_strobe_style ? ds_lo :
	                     i_byte_width_select ? ~w8_hi : b16_lo;

	// word target, lower four codes remapped while pseudo transfer is enabled and acknowledged
	always_comb
	begin
		o_target = HPR_T_CTRL;
		unique case (word_sel)
			`HPR_SEL_DATA:     o_target = remap ? HPR_T_PDATA : HPR_T_DATA;
			`HPR_SEL_DATA_INC: o_target = remap ? HPR_T_LEN : HPR_T_DATA_INC;
			`HPR_SEL_ADDR:     o_target = remap ? HPR_T_PADDR : HPR_T_ADDR;
			`HPR_SEL_CMDSTS:   o_target = remap ? HPR_T_PADDR_EXT : HPR_T_CMDSTS;
			`HPR_SEL_CTRL:     o_target = HPR_T_CTRL;
			`HPR_SEL_ADDR2:    o_target = HPR_T_ADDR;
			`HPR_SEL_ADDR_EXT: o_target = HPR_T_ADDR_EXT;
			`HPR_SEL_LEN:      o_target = HPR_T_LEN;
		endcase
	end

endmodule : hpr_decode

//--- src/hpr_top.sv
// host register port and adapter control register of the lan adapter
// Functional notes
// - normal word map of eight select codes
// - pseudo transfer remaps lower four codes
// - eight-bit port: four selects, byte by lowest
// - data strobes pick high, low or word
// - bits 0-2 mirror configuration pins
// - configuration pins decode to network type
// - bit 3 reserved, read value undefined
// - soft acknowledge replaces grant in pseudo mode
// - ack, request give pending, interrupt, progress
// - bit 5 shows pseudo transfer direction
// - bit 6 shows bus request, same in both styles
// - bit 7 selects pseudo or master transfer
// - bit 8 holds adapter in reset
// - clock failure sets adapter reset bit
// - bit 9 halts processor bus access
// - reset-time fields writable only during reset
`timescale 1ns/1ns
`include "hpr_cfg.svh"
module hpr_top
	import hpr_pkg::*;
(
	input  wire logic        i_ref_clk,
	input  wire logic        i_rst_n,
	// host side pins, asynchronous to i_ref_clk
	input  wire logic        i_byte_strobe_style,
	input  wire logic        i_byte_width_select,
	input  wire logic        i_host_select_n,
	input  wire logic        i_read_n,
	input  wire logic        i_write_n,
	input  wire logic        i_read_not_write,
	input  wire logic        i_upper_strobe_n,
	input  wire logic        i_lower_strobe_n,
	input  wire logic        i_byte_high_enable_n,
	input  wire logic        i_reg_sel_top,
	input  wire logic        i_reg_sel_a,
	input  wire logic        i_reg_sel_b,
	input  wire logic        i_reg_sel_c,
	input  wire logic [15:0] i_host_data,
	output logic      [15:0] o_host_data,
	output logic             o_host_data_oe,
	// board level pins
	input  wire logic        i_net_cfg_pin_a,
	input  wire logic        i_net_cfg_pin_b,
	input  wire logic        i_net_cfg_pin_c,
	input  wire logic        i_bus_grant_in,
	input  wire logic        i_clock_fail,
	output logic             o_bus_request_out,
	output logic             o_xfer_direction_out,
	// adapter side, same clock
	input  wire logic        i_dma_request,
	input  wire logic        i_dma_direction,
	input  wire logic [7:0]  i_status_byte,
	output logic      [7:0]  o_cmd_byte,
	output logic             o_cmd_strobe,
	output logic             o_bus_grant_eff,
	output logic             o_pseudo_irq,
	output logic             o_adapter_reset,
	output logic             o_processor_halt,
	output hpr_net_type      o_net_type
);

	// synchronised pins
	logic [`HPR_SYNC_W-1:0] pin_raw;   // all asynchronous pins
	logic [`HPR_SYNC_W-1:0] pin_sync;  // after two flip-flops
	logic                   s_style;   // byte strobe style
	logic                   s_width8;  // eight-bit port
	logic                   s_sel_n;   // chip select
	logic                   s_rd_n;    // byte style read strobe
	logic                   s_wr_n;    // byte style write strobe
	logic                   s_rnw;     // data style direction
	logic                   s_uds_n;   // upper data strobe
	logic                   s_lds_n;   // lower data strobe
	logic                   s_bhe_n;   // byte high enable
	logic [3:0]             s_rsel;    // top, a, b, c
	logic [2:0]             s_cfg;     // network configuration pins
	logic                   s_grant;   // external bus grant
	logic                   s_cfail;   // clock failure indication
	logic [15:0]            s_data;    // host write data

	assign pin_raw = {i_byte_strobe_style, i_byte_width_select,
		i_host_select_n, i_read_n, i_write_n, i_read_not_write,
		i_upper_strobe_n, i_lower_strobe_n, i_byte_high_enable_n,
		i_reg_sel_top, i_reg_sel_a, i_reg_sel_b, i_reg_sel_c,
		i_net_cfg_pin_c, i_net_cfg_pin_b, i_net_cfg_pin_a,
		i_bus_grant_in, i_clock_fail, i_host_data};
	assign {s_style, s_width8, s_sel_n, s_rd_n, s_wr_n, s_rnw,
		s_uds_n, s_lds_n, s_bhe_n, s_rsel, s_cfg, s_grant, s_cfail,
		s_data} = pin_sync;

	// every host pin is retimed; costs two cycles of access latency
	hpr_sync #(
		.W (`HPR_SYNC_W)
	) u_sync (
		.i_ref_clk (i_ref_clk),
		.i_rst_n   (i_rst_n),
		.i_async   (pin_raw),
		.o_sync    (pin_sync)
	);

	// control register state
	logic ack;      // soft hold acknowledge
	logic enable;   // pseudo transfer enable
	logic adapter_reset_bit;   // adapter reset
	logic halt;     // processor halt

	// word registers behind the port
	logic [15:0] addr_ptr;     // host address pointer
	logic [15:0] addr_ext;     // host address extension
	logic [15:0] xfer_len;     // transfer length
	logic [15:0] pdata;        // pseudo transfer data
	logic [15:0] paddr;        // pseudo transfer address
	logic [15:0] paddr_ext;    // pseudo transfer address extension
	logic [15:0] win_mem [`HPR_MEM_WORDS]; // local memory behind the window

	// access sequencer
	hpr_state_type state;
	hpr_state_type next_state;

	// decode of the current access
	hpr_target_type target;
	logic           lane_hi;
	logic           lane_lo;
	logic           narrow;
	logic           undefined;
	wire            pseudo_active = enable & ack;

	hpr_decode u_decode (
		.i_byte_strobe_style  (s_style),
		.i_byte_width_select  (s_width8),
		.i_reg_sel_top        (s_rsel[3]),
		.i_reg_sel_a          (s_rsel[2]),
		.i_reg_sel_b          (s_rsel[1]),
		.i_reg_sel_c          (s_rsel[0]),
		.i_byte_high_enable_n (s_bhe_n),
		.i_upper_strobe_n     (s_uds_n),
		.i_lower_strobe_n     (s_lds_n),
		.i_pseudo_active      (pseudo_active),
		.o_target             (target),
		.o_lane_hi            (lane_hi),
		.o_lane_lo            (lane_lo),
		.o_narrow             (narrow),
		.o_undefined          (undefined)
	);

	// access level per bus style
	wire bs_active = ~s_sel_n & (~s_rd_n | ~s_wr_n);
	wire ds_active = ~s_sel_n & (~s_uds_n | ~s_lds_n);
	wire active    = s_style ? bs_active : ds_active;
	wire is_read   = s_style ? ~s_rd_n : s_rnw;
	wire start     = (state == HPR_ST_IDLE) & active;
	// undefined selects are refused for writes; reads still answer
	wire do_wr     = start & ~is_read & ~undefined;
	wire do_rd     = start & is_read;

	// write data on lanes; eight-bit port carries each byte low
	wire [7:0]  wd_hi = narrow ? s_data[7:0] : s_data[15:8];
	wire [7:0]  wd_lo = s_data[7:0];
	wire [15:0] wd    = {wd_hi, wd_lo};

	// merge the addressed lanes into an old word
	function automatic logic [15:0] merge(input logic [15:0] old,
		input logic hi, input logic lo, input logic [15:0] nw);
		merge = {hi ? nw[15:8] : old[15:8], lo ? nw[7:0] : old[7:0]};
	endfunction : merge

	// network type decode of the configuration pins
	hpr_net_type net_now;
	always_comb
	begin
		net_now = HPR_NET_RESERVED;
		if (s_cfg[2])
		begin
			unique case (s_cfg[1:0])
				2'h0: net_now = HPR_NET_RESERVED;
				2'h2: net_now = HPR_NET_RING16; // pin a low, pin b high
				2'h1: net_now = HPR_NET_CSMA;   // pin a high, pin b low
				2'h3: net_now = HPR_NET_RING4;
			endcase
		end
	end

	// control register read view
	wire [15:0] ctrl_view = {6'h00, halt, adapter_reset_bit, enable,
		i_dma_request,
		i_dma_direction,
		ack,
		1'b0,
		s_cfg};

	// control register next values
	wire ctl_lo_wr   = do_wr & (target == HPR_T_CTRL) & lane_lo;
	wire ctl_hi_wr   = do_wr & (target == HPR_T_CTRL) & lane_hi;
	wire next_enable = ctl_lo_wr ? wd[`HPR_CTL_ENABLE] : enable;
	// acknowledge cannot stand while pseudo mode is off
	wire next_ack    = next_enable &
		(ctl_lo_wr ? wd[`HPR_CTL_ACK] : ack);
	// clock failure sets adapter reset and beats a host clear
	wire next_adapter_reset_bit = s_cfail |
		(ctl_hi_wr ? wd[`HPR_CTL_ADAPTER_RESET_BIT] : adapter_reset_bit);
	// halt is writable only while the adapter is held in reset
	wire next_halt   = (ctl_hi_wr & adapter_reset_bit) ?
		wd[`HPR_CTL_HALT] : halt;

	// control register, kept alive through adapter reset
	always_ff @(posedge i_ref_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			ack    <= `HPR_RST_ACK;
			enable <= `HPR_RST_ENABLE;
			adapter_reset_bit <= `HPR_RST_ADAPTER_RESET_BIT;
			halt   <= `HPR_RST_HALT;
		end
		else
		begin
			ack    <= next_ack;
			enable <= next_enable;
			adapter_reset_bit <= next_adapter_reset_bit;
			halt   <= next_halt;
		end
	end

	// window addressing and auto increment
	wire [`HPR_MEM_AW-1:0] win_idx = addr_ptr[`HPR_MEM_AW:1];
	wire win_hit  = (target == HPR_T_DATA) | (target == HPR_T_DATA_INC);
	// step once the high byte or the whole word has gone by
	wire inc_step = start & ~undefined & (target == HPR_T_DATA_INC) &
		lane_hi;
	wire wr_addr  = do_wr & (target == HPR_T_ADDR);
	wire [15:0] next_addr = wr_addr ? merge(addr_ptr, lane_hi, lane_lo, wd) :
		inc_step ? addr_ptr + `HPR_ADDR_STEP : addr_ptr;

	// word registers; adapter reset clears them like the reset pin
	always_ff @(posedge i_ref_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			addr_ptr  <= `HPR_RST_WORD;
			addr_ext  <= `HPR_RST_WORD;
			xfer_len  <= `HPR_RST_WORD;
			pdata     <= `HPR_RST_WORD;
			paddr     <= `HPR_RST_WORD;
			paddr_ext <= `HPR_RST_WORD;
		end
		else if (adapter_reset_bit)
		begin
			addr_ptr  <= `HPR_RST_WORD;
			addr_ext  <= `HPR_RST_WORD;
			xfer_len  <= `HPR_RST_WORD;
			pdata     <= `HPR_RST_WORD;
			paddr     <= `HPR_RST_WORD;
			paddr_ext <= `HPR_RST_WORD;
		end
		else
		begin
			addr_ptr <= next_addr;
			if (do_wr & (target == HPR_T_ADDR_EXT))
				addr_ext <= merge(addr_ext, lane_hi, lane_lo, wd);
			if (do_wr & (target == HPR_T_LEN))
				xfer_len <= merge(xfer_len, lane_hi, lane_lo, wd);
			if (do_wr & (target == HPR_T_PDATA))
				pdata <= merge(pdata, lane_hi, lane_lo, wd);
			if (do_wr & (target == HPR_T_PADDR))
				paddr <= merge(paddr, lane_hi, lane_lo, wd);
			if (do_wr & (target == HPR_T_PADDR_EXT))
				paddr_ext <= merge(paddr_ext, lane_hi, lane_lo, wd);
		end
	end

	// window memory, no reset: contents are don't care until loaded
	always_ff @(posedge i_ref_clk)
	begin
		if (do_wr & win_hit & ~adapter_reset_bit)
			win_mem[win_idx] <= merge(win_mem[win_idx], lane_hi, lane_lo, wd);
	end

	// read word selection
	logic [15:0] rd_word;
	always_comb
	begin
		rd_word = `HPR_RST_WORD;
		unique case (target)
			HPR_T_DATA,
			HPR_T_DATA_INC:  rd_word = win_mem[win_idx];
			HPR_T_ADDR:      rd_word = addr_ptr;
			HPR_T_CMDSTS:    rd_word = {o_cmd_byte, i_status_byte};
			HPR_T_CTRL:      rd_word = ctrl_view;
			HPR_T_ADDR_EXT:  rd_word = addr_ext;
			HPR_T_LEN:       rd_word = xfer_len;
			HPR_T_PDATA:     rd_word = pdata;
			HPR_T_PADDR:     rd_word = paddr;
			HPR_T_PADDR_EXT: rd_word = paddr_ext;
		endcase
	end

	// undefined select reads as zero; eight-bit port byte reads placed on the low lane
	wire [15:0] rd_lane = undefined ? `HPR_RST_WORD :
		(narrow & lane_hi) ? {8'h00, rd_word[15:8]} :
		narrow ? {8'h00, rd_word[7:0]} : rd_word;

	// command byte: high lane of the command and status word
	wire cmd_wr = do_wr & (target == HPR_T_CMDSTS) & lane_hi;

	// sequencer: one register action per host strobe
	always_comb
	begin
		next_state = state;
		unique case (state)
			HPR_ST_IDLE: if (active) next_state = HPR_ST_BUSY;
			HPR_ST_BUSY: if (!active) next_state = HPR_ST_IDLE;
		endcase
	end

	// sequencer state and host data drive
	always_ff @(posedge i_ref_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			state          <= HPR_ST_IDLE;
			o_host_data    <= `HPR_RST_WORD;
			o_host_data_oe <= 1'b0;
		end
		else
		begin
			state <= next_state;
			if (do_rd)
				o_host_data <= rd_lane;
			// drive only while the read strobe is still present
			o_host_data_oe <= (do_rd | (state == HPR_ST_BUSY)) & active &
				is_read;
		end
	end

	// command path and adapter side outputs
	always_ff @(posedge i_ref_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			o_cmd_byte           <= `HPR_RST_BYTE;
			o_cmd_strobe         <= 1'b0;
			o_bus_grant_eff      <= 1'b0;
			o_pseudo_irq         <= 1'b0;
			o_adapter_reset      <= `HPR_RST_ADAPTER_RESET_BIT;
			o_processor_halt     <= `HPR_RST_HALT;
			o_bus_request_out    <= 1'b0;
			o_xfer_direction_out <= 1'b0;
			o_net_type           <= HPR_NET_RESERVED;
		end
		else
		begin
			if (cmd_wr & ~adapter_reset_bit)
				o_cmd_byte <= wd_hi;
			o_cmd_strobe <= cmd_wr & ~adapter_reset_bit;
			// grant pin ignored while pseudo mode is on
			o_bus_grant_eff <= enable ? ack : s_grant;
			o_pseudo_irq    <= enable & ~ack & i_dma_request;
			o_adapter_reset <= adapter_reset_bit;
			o_processor_halt <= halt;
			// data strobe style drives the request pin inverted
			o_bus_request_out <= s_style ? i_dma_request :
				~i_dma_request;
			o_xfer_direction_out <= i_dma_direction;
			o_net_type <= net_now;
		end
	end

endmodule : hpr_top

//--- verification/hpr_top_sva.sv
// checker for the host register port top
`timescale 1ns/1ns
module hpr_top_sva
	import hpr_pkg::*;
(
	input  wire logic  i_ref_clk,
	input  wire logic  i_rst_n,
	input  wire logic  i_byte_strobe_style,
	input  wire logic  i_host_select_n,
	input  wire logic  i_net_cfg_pin_a,
	input  wire logic  i_net_cfg_pin_b,
	input  wire logic  i_net_cfg_pin_c,
	input  wire logic  i_clock_fail,
	input  wire logic  i_dma_request,
	input  wire logic  i_dma_direction,
	input  wire logic  o_host_data_oe,
	input  wire logic  o_bus_request_out,
	input  wire logic  o_xfer_direction_out,
	input  wire logic  o_cmd_strobe,
	input  wire logic  o_pseudo_irq,
	input  wire logic  o_adapter_reset,
	input  hpr_net_type o_net_type
);
	logic [2:0]  up_cnt;  // edges since reset, saturating
	wire         up;      // synchronisers flushed of reset values
	wire  [2:0]  cfg;     // pins {c, b, a}
	hpr_net_type exp_net; // decode expected from the pins
	assign up = (up_cnt == 3'h7);
	assign cfg = {i_net_cfg_pin_c, i_net_cfg_pin_b, i_net_cfg_pin_a};
	// enum order matches {a, b} when pin c is high
	assign exp_net = cfg[2] ? hpr_net_type'({1'b0, cfg[0], cfg[1]})
		: HPR_NET_RESERVED;
	// synced inputs read 0 just after reset
	always_ff @(posedge i_ref_clk or negedge i_rst_n)
		if (!i_rst_n)
			up_cnt <= 3'h0;
		else if (!up)
			up_cnt <= up_cnt + 3'h1;
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_rst_n);
	// pins held long enough to pass the synchroniser
	sequence s_cfg_steady;
		(up && $stable(cfg)) [*4];
	endsequence
	sequence s_style_steady;
		(up && $stable(i_byte_strobe_style)) [*4];
	endsequence
	sequence s_fail_held;
		(up && i_clock_fail) [*3];
	endsequence
	a_net_decode: assert property (s_cfg_steady |-> o_net_type == exp_net)
		else $error("network type decode wrong");
	a_cmd_pulse: assert property (o_cmd_strobe |=> !o_cmd_strobe)
		else $error("command strobe longer than one cycle");
	a_irq_cause: assert property (o_pseudo_irq |-> $past(i_dma_request))
		else $error("pseudo interrupt without request");
	a_req_style: assert property (s_style_steady |=>
		o_bus_request_out == ($past(i_byte_strobe_style) == $past(i_dma_request)))
		else $error("bus request polarity wrong for style");
	a_dir_delay: assert property (up |=>
		o_xfer_direction_out == $past(i_dma_direction))
		else $error("direction output not following input");
	a_fail_reset: assert property (s_fail_held |-> ##[1:5] o_adapter_reset)
		else $error("clock failure did not set adapter reset");
	a_oe_cause: assert property ($rose(o_host_data_oe) |->
		$past(!i_host_select_n, 2))
		else $error("data driven without select");
	a_oe_release: assert property (i_host_select_n [*6] |-> !o_host_data_oe)
		else $error("data still driven after release");
endmodule : hpr_top_sva
bind hpr_top hpr_top_sva hpr_top_sva_inst (.i_ref_clk, .i_rst_n,
	.i_byte_strobe_style, .i_host_select_n, .i_net_cfg_pin_a,
	.i_net_cfg_pin_b, .i_net_cfg_pin_c, .i_clock_fail, .i_dma_request,
	.i_dma_direction, .o_host_data_oe, .o_bus_request_out,
	.o_xfer_direction_out, .o_cmd_strobe, .o_pseudo_irq, .o_adapter_reset,
	.o_net_type);

//--- verification/hpr_host_model.sv
// host processor model driving the register port pins
`timescale 1ns/1ns
module hpr_host_model (
	input  wire logic        i_ref_clk,
	input  wire logic        i_byte_strobe_style,
	input  wire logic [15:0] i_host_data,
	input  wire logic        i_host_data_oe,
	output logic             o_host_select_n,
	output logic             o_read_n,
	output logic             o_write_n,
	output logic             o_read_not_write,
	output logic             o_upper_strobe_n,
	output logic             o_lower_strobe_n,
	output logic             o_byte_high_enable_n,
	output logic      [3:0]  o_reg_sel,
	output logic      [15:0] o_host_data
);
	// released bus: no pull-ups, so show the inverse
	task automatic free_bus;
		o_host_select_n = 1'b1;
		o_read_n = 1'b1;
		o_write_n = 1'b1;
		o_upper_strobe_n = 1'b1;
		o_lower_strobe_n = 1'b1;
		o_host_data = ~o_host_data;
	endtask : free_bus
	// time zero: idle bus
	initial
	begin
		o_read_not_write = 1'b1;
		o_byte_high_enable_n = 1'b0;
		o_reg_sel = 4'h0;
		o_host_data = 16'h0000;
		free_bus();
	end
	// one access, held until answered, then released
	task automatic xfer(input logic rd, input logic [3:0] sel,
		input logic bhe_n, input logic [1:0] ds_n,
		input logic [15:0] wd, output logic [15:0] rdt);
		int n;
		rdt = 16'hxxxx;
		n = 0;
		@(negedge i_ref_clk);
		o_reg_sel = sel;
		o_byte_high_enable_n = bhe_n;
		o_host_data = wd;
		o_read_not_write = rd;
		o_host_select_n = 1'b0;
		// selects settle ahead of the strobe
		repeat (3) @(negedge i_ref_clk);
		if (i_byte_strobe_style)
		begin
			o_read_n = !rd;
			o_write_n = rd;
		end
		else
			{o_upper_strobe_n, o_lower_strobe_n} = ds_n;
		// reads wait for the answer, writes hold a few edges
		do
		begin
			@(posedge i_ref_clk);
			n++;
		end
		while (n < 12 && (rd ? i_host_data_oe !== 1'b1 : n < 5));
		if (rd && i_host_data_oe === 1'b1)
			rdt = i_host_data;
		@(negedge i_ref_clk);
		free_bus();
		repeat (6) @(negedge i_ref_clk);
	endtask : xfer
endmodule : hpr_host_model

//--- verification/hpr_top_tb.sv
// testbench for the host register port top
`timescale 1ns/1ns
module hpr_top_tb
	import hpr_pkg::*;
;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        style = 1'b1;  // byte strobes
	logic        width8 = 1'b0; // 16-bit port
	logic [2:0]  cfg = 3'h5;    // pins {c, b, a}
	logic        grant = 1'b0, cfail = 1'b0, req = 1'b0, dir = 1'b0;
	logic [7:0]  sts = 8'h3c;
	logic        sel_n, rd_n, wr_n, rnw, uds_n, lds_n, bhe_n;
	logic [3:0]  sel;           // {top, a, b, c}
	logic [15:0] hd, od, rv;
	logic        oe, breq, xdir, cstb, geff, irq, ares, halt;
	logic [7:0]  cmd;
	hpr_net_type net;
	int          miscompares = 0;
	int          check_count = 0;
	int          cycles = 0;
	always #5 clk = ~clk;
	hpr_top hpr_top_inst (
		.i_ref_clk(clk), .i_rst_n(rst_n), .i_byte_strobe_style(style),
		.i_byte_width_select(width8), .i_host_select_n(sel_n),
		.i_read_n(rd_n), .i_write_n(wr_n), .i_read_not_write(rnw),
		.i_upper_strobe_n(uds_n), .i_lower_strobe_n(lds_n),
		.i_byte_high_enable_n(bhe_n), .i_reg_sel_top(sel[3]),
		.i_reg_sel_a(sel[2]), .i_reg_sel_b(sel[1]), .i_reg_sel_c(sel[0]),
		.i_host_data(hd), .o_host_data(od), .o_host_data_oe(oe),
		.i_net_cfg_pin_a(cfg[0]), .i_net_cfg_pin_b(cfg[1]),
		.i_net_cfg_pin_c(cfg[2]), .i_bus_grant_in(grant),
		.i_clock_fail(cfail), .o_bus_request_out(breq),
		.o_xfer_direction_out(xdir), .i_dma_request(req),
		.i_dma_direction(dir), .i_status_byte(sts), .o_cmd_byte(cmd),
		.o_cmd_strobe(cstb), .o_bus_grant_eff(geff), .o_pseudo_irq(irq),
		.o_adapter_reset(ares), .o_processor_halt(halt), .o_net_type(net));
	hpr_host_model hpr_host_model_inst (
		.i_ref_clk(clk), .i_byte_strobe_style(style), .i_host_data(od),
		.i_host_data_oe(oe), .o_host_select_n(sel_n), .o_read_n(rd_n),
		.o_write_n(wr_n), .o_read_not_write(rnw), .o_upper_strobe_n(uds_n),
		.o_lower_strobe_n(lds_n), .o_byte_high_enable_n(bhe_n),
		.o_reg_sel(sel), .o_host_data(hd));
	task automatic results;
		$display("checks %0d miscompares %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : results
	// hang guard, far above the expected run
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			miscompares++;
			results();
		end
	end
	task automatic chk(input string what, input logic [15:0] seen,
		input logic [15:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
			miscompares++;
		end
	endtask : chk
	// byte-style shorthands
	task automatic wr(input logic [3:0] s, input logic b, input logic [15:0] d);
		hpr_host_model_inst.xfer(1'b0, s, b, 2'b11, d, rv);
	endtask : wr
	task automatic rd(input logic [3:0] s, input logic b);
		hpr_host_model_inst.xfer(1'b1, s, b, 2'b11, 16'h0000, rv);
	endtask : rd
	task automatic idle(input int n);
		repeat (n) @(negedge clk);
	endtask : idle
	// control word from pins and {halt, adapter_reset_bit, enable, ack}
	function automatic logic [15:0] ctl(input logic [3:0] w);
		return {6'h00, w[3:1], req, dir, w[0], 1'b0, cfg};
	endfunction : ctl
	task automatic t_cfg;
		hpr_net_type e;
		for (int i = 0; i < 8; i++)
		begin
			cfg = 3'(i);
			idle(6);
			e = cfg[2] ? hpr_net_type'({1'b0, cfg[0], cfg[1]}) : HPR_NET_RESERVED;
			chk("net type", 16'(net), 16'(e));
			rd(4'h8, 1'b0);
			chk("ctl pins", rv, ctl(4'hc));
		end
		chk("held outs", 16'({ares, halt}), 16'h0003);
		$display("t_cfg end");
	endtask : t_cfg
	task automatic t_ctrl;
		wr(4'h8, 1'b0, 16'h0010);
		rd(4'h8, 1'b0);
		chk("ack halt", rv, ctl(4'h0));
		chk("run outs", 16'({ares, halt}), 16'h0000);
		wr(4'h8, 1'b0, 16'h0200);
		rd(4'h8, 1'b0);
		chk("halt lock", rv, ctl(4'h0));
		$display("t_ctrl end");
	endtask : t_ctrl
	task automatic t_pseudo;
		req = 1'b1;
		dir = 1'b1;
		grant = 1'b1;
		wr(4'h8, 1'b0, 16'h0080);
		rd(4'h8, 1'b0);
		chk("enable", rv, ctl(4'h2));
		chk("irq grant", 16'({irq, geff}), 16'h0002);
		chk("dir out", 16'(xdir), 16'h0001);
		wr(4'h8, 1'b0, 16'h0090);
		grant = 1'b0;
		wr(4'h2, 1'b0, 16'h1234);
		wr(4'h4, 1'b0, 16'h5678);
		rd(4'he, 1'b0);
		chk("remap len", rv, 16'h1234);
		rd(4'ha, 1'b0);
		chk("addr kept", rv, 16'h0000);
		rd(4'h4, 1'b0);
		chk("ps addr", rv, 16'h5678);
		chk("irq grant", 16'({irq, geff}), 16'h0001);
		grant = 1'b1;
		wr(4'h8, 1'b0, 16'h0010);
		rd(4'h8, 1'b0);
		chk("ack off", rv, ctl(4'h0));
		chk("grant pin", 16'({irq, geff}), 16'h0001);
		$display("t_pseudo end");
	endtask : t_pseudo
	task automatic t_map;
		wr(4'h4, 1'b0, 16'h0a5c);
		wr(4'h0, 1'b0, 16'hbeef);
		rd(4'h2, 1'b0);
		chk("window", rv, 16'hbeef);
		rd(4'ha, 1'b0);
		chk("addr alias", rv, 16'h0a5e);
		wr(4'hf, 1'b1, 16'hffff);
		wr(4'hf, 1'b0, 16'h9900);
		rd(4'he, 1'b0);
		chk("undef hi", rv, 16'h9934);
		wr(4'he, 1'b1, 16'h0077);
		width8 = 1'b1;
		idle(5);
		wr(4'h7, 1'b1, 16'h00a5);
		chk("cmd byte", 16'(cmd), 16'h00a5);
		rd(4'h6, 1'b1);
		chk("status", rv & 16'h00ff, 16'(sts));
		rd(4'hf, 1'b1);
		chk("len msb", rv & 16'h00ff, 16'h0099);
		width8 = 1'b0;
		style = 1'b0;
		idle(5);
		chk("req inv", 16'(breq), 16'h0000);
		hpr_host_model_inst.xfer(1'b0, 4'he, 1'b1, 2'b01, 16'h4400, rv);
		hpr_host_model_inst.xfer(1'b1, 4'he, 1'b1, 2'b00, 16'h0000, rv);
		chk("ds word", rv, 16'h4477);
		hpr_host_model_inst.xfer(1'b0, 4'he, 1'b1, 2'b10, 16'h0011, rv);
		hpr_host_model_inst.xfer(1'b1, 4'he, 1'b1, 2'b00, 16'h0000, rv);
		chk("ds low", rv, 16'h4411);
		style = 1'b1;
		idle(5);
		chk("req out", 16'(breq), 16'h0001);
		$display("t_map end");
	endtask : t_map
	task automatic t_fail;
		cfail = 1'b1;
		idle(6);
		cfail = 1'b0;
		chk("fail rst", 16'(ares), 16'h0001);
		wr(4'he, 1'b0, 16'h1111);
		rd(4'he, 1'b0);
		chk("len held", rv, 16'h0000);
		rd(4'h8, 1'b0);
		chk("ctl fail", rv, ctl(4'h4));
		$display("t_fail end");
	endtask : t_fail
	initial
	begin
		repeat (20) @(negedge clk);
		rst_n = 1'b1;
		idle(4);
		t_cfg();
		t_ctrl();
		t_pseudo();
		t_map();
		t_fail();
		results();
	end
endmodule : hpr_top_tb
